// ===== hw/bcg_clk_gate.sv
// One glitch-free secondary clock output gate.
// Assumes a shared phase toggling every aclk cycle.
`timescale 1ns/100ps
module bcg_clk_gate
(
    input  wire logic aclk,
    input  wire logic aresetn,
    bcg_gate_if.gate  g
);
    logic en_r;
    logic en_nxt;
    logic clk_r;
    logic clk_nxt;

    always_comb
    begin
        // Enable may only change while the output is low
        en_nxt  = clk_r ? en_r : ~g.disable_req;
        clk_nxt = en_nxt & g.phase_next;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_r  <= 1'b0;
            clk_r <= 1'b0;
        end
        else
        begin
            en_r  <= en_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign g.clk_out = clk_r;
endmodule

// ===== hw/bcg_gate_if.sv
// Link between the register bank and one secondary clock gate.
// Assumes both ends run on aclk.
`timescale 1ns/100ps
interface bcg_gate_if;
    logic phase_next;
    logic disable_req;
    logic clk_out;
    modport ctl  (output phase_next, output disable_req, input clk_out);
    modport gate (input phase_next, input disable_req, output clk_out);
endinterface

// ===== hw/bcg_pkg.sv
// Constants for the secondary clock gating and system-error cause registers.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package bcg_pkg;
    localparam int          AXI_ADDR_W   = 8;
    localparam int          AXI_DATA_W   = 32;
    localparam logic [7:0]  CLK_STAT_OFS = 8'h68;
    localparam logic [7:0]  SERR_MSK_OFS = 8'h6c;
    localparam logic [7:0]  CTRL_OFS     = 8'h70;
    localparam logic [7:0]  IRQ_MSK_OFS  = 8'h74;

    localparam int          NUM_CLKS     = 10;
    localparam int          PAIRED_CLKS  = 4;
    localparam int          SINGLE_BASE  = 8;
    localparam int          CLK_CTRL_W   = 16;
    localparam logic [15:0] CLK_RW_MASK  = 16'h3fff;
    localparam logic [15:0] CLK_CTRL_RST = 16'h0000;

    localparam int          STAT_LSB     = 16;
    localparam int          STAT_W       = 8;
    localparam int          STAT_BYTE    = 2;
    localparam logic [7:0]  STAT_RST     = 8'h00;
    localparam logic [7:0]  MSK_RST      = 8'h00;
    localparam int          SERR_EN_BIT  = 0;

    // Cause flag positions
    localparam int EV_ADDR_PAR   = 0;
    localparam int EV_PW_PAR     = 1;
    localparam int EV_PW_NODEL   = 2;
    localparam int EV_PW_TABORT  = 3;
    localparam int EV_PW_MABORT  = 4;
    localparam int EV_DW_NODEL   = 5;
    localparam int EV_DR_NODATA  = 6;
    localparam int EV_DT_TIMEOUT = 7;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;
endpackage

// ===== hw/bcg_top.sv
// Secondary clock gating and system-error cause register bank.
// Assumes error pulses come from logic on aclk, one cycle each.
//
// Operation
// - Clock output 0 stops only when both bits 1:0 are set.
// - Clock output 1 stops only when both bits 3:2 are set.
// - Clock output 2 stops only when both bits 5:4 are set.
// - Clock output 3 stops only when both bits 7:6 are set.
// - Bits 8 to 13 each stop clock outputs 4 to 9, held low.
// - Clock control bits 15:14 read zero and ignore writes.
// - Address parity cause flag set when system error asserted for it.
// - Posted write data parity cause flag set when system error asserted.
// - Posted write non-delivery cause flag set when system error asserted.
// - Posted write target abort cause flag set when system error asserted.
// - Cause flags reset to zero, clear only by writing one.
// - System error asserts only when unmasked and enable bit set.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module bcg_top
#(
    parameter int CLK_COUNT = bcg_pkg::NUM_CLKS
)
(
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [bcg_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [bcg_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [bcg_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [bcg_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic [bcg_pkg::STAT_W-1:0]      err_event,
    output logic [CLK_COUNT-1:0]                 secondary_bus_clock_outputs,
    output logic                                 primary_system_error_n_out,
    output logic                                 primary_system_error_n_oe,
    output logic                                 irq
);
    localparam int AW = bcg_pkg::AXI_ADDR_W;
    localparam int DW = bcg_pkg::AXI_DATA_W;
    localparam int SW = bcg_pkg::STAT_W;

    if (CLK_COUNT != bcg_pkg::NUM_CLKS)
    begin : g_bad_count
        $error("CLK_COUNT must equal the fixed field layout");
    end

    if (bcg_pkg::STAT_LSB + SW > DW)
    begin : g_bad_stat
        $error("Cause flags must fit the data word");
    end

    logic          awready_r, awready_nxt;
    logic          wready_r,  wready_nxt;
    logic          arready_r, arready_nxt;
    logic          aw_held_r, aw_held_nxt;
    logic          w_held_r,  w_held_nxt;
    logic [AW-1:0] awaddr_r,  awaddr_nxt;
    logic [DW-1:0] wdata_r,   wdata_nxt;
    logic [3:0]    wstrb_r,   wstrb_nxt;
    logic          bvalid_r,  bvalid_nxt;
    logic [1:0]    bresp_r,   bresp_nxt;
    logic          rvalid_r,  rvalid_nxt;
    logic [1:0]    rresp_r,   rresp_nxt;
    logic [DW-1:0] rdata_r,   rdata_nxt;

    logic [bcg_pkg::CLK_CTRL_W-1:0] clk_ctrl_r, clk_ctrl_nxt;
    logic [SW-1:0] stat_r,     stat_nxt;
    logic [SW-1:0] serr_msk_r, serr_msk_nxt;
    logic [SW-1:0] irq_msk_r,  irq_msk_nxt;
    logic          serr_en_r,  serr_en_nxt;
    logic          serr_oe_r,  serr_oe_nxt;
    logic          serr_val_r, serr_val_nxt;
    logic          irq_r,      irq_nxt;
    logic          phase_r,    phase_nxt;

    logic          do_wr;
    logic [SW-1:0] fire;
    logic [SW-1:0] clr;

    function automatic logic mapped(input logic [AW-1:0] a);
        logic [AW-1:0] w;
        w = {a[AW-1:2], 2'h0};
        mapped = (w == bcg_pkg::CLK_STAT_OFS) || (w == bcg_pkg::SERR_MSK_OFS)
              || (w == bcg_pkg::CTRL_OFS) || (w == bcg_pkg::IRQ_MSK_OFS);
    endfunction

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0]    ofs);
        hit = ({a[AW-1:2], 2'h0} == ofs);
    endfunction

    // Byte-lane merge for narrow registers in the low byte
    function automatic logic [SW-1:0] lane0(input logic [SW-1:0] old,
                                            input logic [DW-1:0] d,
                                            input logic [3:0]    s);
        lane0 = s[0] ? d[SW-1:0] : old;
    endfunction

    always_comb
    begin
        logic [DW-1:0] rd;
        rd           = '0;
        awready_nxt  = awready_r;
        wready_nxt   = wready_r;
        arready_nxt  = arready_r;
        aw_held_nxt  = aw_held_r;
        w_held_nxt   = w_held_r;
        awaddr_nxt   = awaddr_r;
        wdata_nxt    = wdata_r;
        wstrb_nxt    = wstrb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        rvalid_nxt   = rvalid_r;
        rresp_nxt    = rresp_r;
        rdata_nxt    = rdata_r;
        clk_ctrl_nxt = clk_ctrl_r;
        serr_msk_nxt = serr_msk_r;
        irq_msk_nxt  = irq_msk_r;
        serr_en_nxt  = serr_en_r;
        clr          = '0;

        if (s_axi_awvalid && awready_r)
        begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end

        // Next write waits until the last response is taken
        do_wr = aw_held_r && w_held_r && !bvalid_r;
        if (do_wr)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = mapped(awaddr_r) ? bcg_pkg::RESP_OKAY
                                           : bcg_pkg::RESP_DECERR;
            if (hit(awaddr_r, bcg_pkg::CLK_STAT_OFS))
            begin
                if (wstrb_r[0])
                    clk_ctrl_nxt[7:0] = wdata_r[7:0];
                if (wstrb_r[1])
                    clk_ctrl_nxt[15:8] = wdata_r[15:8];
                // Reserved top bits never stored
                clk_ctrl_nxt = clk_ctrl_nxt & bcg_pkg::CLK_RW_MASK;
                if (wstrb_r[bcg_pkg::STAT_BYTE])
                    clr = wdata_r[bcg_pkg::STAT_LSB +: SW];
            end
            if (hit(awaddr_r, bcg_pkg::SERR_MSK_OFS))
                serr_msk_nxt = lane0(serr_msk_r, wdata_r, wstrb_r);
            if (hit(awaddr_r, bcg_pkg::IRQ_MSK_OFS))
                irq_msk_nxt = lane0(irq_msk_r, wdata_r, wstrb_r);
            if (hit(awaddr_r, bcg_pkg::CTRL_OFS) && wstrb_r[0])
                serr_en_nxt = wdata_r[bcg_pkg::SERR_EN_BIT];
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        awready_nxt = !aw_held_nxt;
        wready_nxt  = !w_held_nxt;

        // Low address bits ignored: reads fold onto the word
        if (s_axi_arvalid && arready_r)
        begin
            if (hit(s_axi_araddr, bcg_pkg::CLK_STAT_OFS))
            begin
                rd[bcg_pkg::CLK_CTRL_W-1:0] = clk_ctrl_r
                                            & bcg_pkg::CLK_RW_MASK;
                rd[bcg_pkg::STAT_LSB +: SW] = stat_r;
            end
            if (hit(s_axi_araddr, bcg_pkg::SERR_MSK_OFS))
                rd[SW-1:0] = serr_msk_r;
            if (hit(s_axi_araddr, bcg_pkg::IRQ_MSK_OFS))
                rd[SW-1:0] = irq_msk_r;
            if (hit(s_axi_araddr, bcg_pkg::CTRL_OFS))
                rd[bcg_pkg::SERR_EN_BIT] = serr_en_r;
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd;
            rresp_nxt  = mapped(s_axi_araddr) ? bcg_pkg::RESP_OKAY
                                              : bcg_pkg::RESP_DECERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        arready_nxt = !rvalid_nxt;

        // Error pulses gated by their mask bit and the global enable
        fire = err_event & ~serr_msk_r & {SW{serr_en_r}};
        // Flags record the cause of each assertion; a new event beats a clear
        stat_nxt = (stat_r & ~clr) | fire;
        serr_oe_nxt = |fire;
        // Pin value from a flop like every other output
        serr_val_nxt = 1'b0;
        irq_nxt     = |(stat_nxt & irq_msk_nxt);
        phase_nxt   = ~phase_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
            arready_r  <= 1'b0;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awaddr_r   <= '0;
            wdata_r    <= '0;
            wstrb_r    <= '0;
            bvalid_r   <= 1'b0;
            bresp_r    <= bcg_pkg::RESP_OKAY;
            rvalid_r   <= 1'b0;
            rresp_r    <= bcg_pkg::RESP_OKAY;
            rdata_r    <= '0;
            clk_ctrl_r <= bcg_pkg::CLK_CTRL_RST;
            stat_r     <= bcg_pkg::STAT_RST;
            serr_msk_r <= bcg_pkg::MSK_RST;
            irq_msk_r  <= bcg_pkg::MSK_RST;
            serr_en_r  <= 1'b0;
            serr_oe_r  <= 1'b0;
            serr_val_r <= 1'b0;
            irq_r      <= 1'b0;
            phase_r    <= 1'b0;
        end
        else
        begin
            awready_r  <= awready_nxt;
            wready_r   <= wready_nxt;
            arready_r  <= arready_nxt;
            aw_held_r  <= aw_held_nxt;
            w_held_r   <= w_held_nxt;
            awaddr_r   <= awaddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb_r    <= wstrb_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rresp_r    <= rresp_nxt;
            rdata_r    <= rdata_nxt;
            clk_ctrl_r <= clk_ctrl_nxt;
            stat_r     <= stat_nxt;
            serr_msk_r <= serr_msk_nxt;
            irq_msk_r  <= irq_msk_nxt;
            serr_en_r  <= serr_en_nxt;
            serr_oe_r  <= serr_oe_nxt;
            serr_val_r <= serr_val_nxt;
            irq_r      <= irq_nxt;
            phase_r    <= phase_nxt;
        end
    end

    // Secondary clocks at half aclk, one gate each
    for (genvar i = 0; i < CLK_COUNT; i++)
    begin : g_clk
        bcg_gate_if gi ();
        assign gi.phase_next = phase_nxt;
        if (i < bcg_pkg::PAIRED_CLKS)
        begin : g_pair
            // Both bits needed so a stray write setting one bit cannot stop it
            assign gi.disable_req =
                &clk_ctrl_r[2*i +: 2];
        end
        else
        begin : g_single
            assign gi.disable_req =
                clk_ctrl_r[bcg_pkg::SINGLE_BASE + i - bcg_pkg::PAIRED_CLKS];
        end
        bcg_clk_gate u_gate
        (
            .aclk    (aclk),
            .aresetn (aresetn),
            .g       (gi.gate)
        );
        assign secondary_bus_clock_outputs[i] = gi.clk_out;
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_arready = arready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    // Open-drain: value always low, enable pulses to pull the line
    assign primary_system_error_n_out = serr_val_r;
    assign primary_system_error_n_oe  = serr_oe_r;
    assign irq = irq_r;
endmodule

// ===== verification/bcg_top_properties.sv
// Port-level checks for the clock gating and error cause register bank.
// Assumes it is bound into bcg_top and sees only that module's ports.
`timescale 1ns/100ps
module bcg_top_properties
#(
    parameter int CLK_COUNT = bcg_pkg::NUM_CLKS
)
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic [7:0]           s_axi_araddr,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic [1:0]           s_axi_rresp,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic [7:0]           err_event,
    input wire logic [CLK_COUNT-1:0] secondary_bus_clock_outputs,
    input wire logic                 primary_system_error_n_out,
    input wire logic                 primary_system_error_n_oe,
    input wire logic                 irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_OE_CAUSE:
    assert property (primary_system_error_n_oe
                     |-> $past(err_event) != 8'h00)
        else $error("error line pulled low with no event");
    AST_OD_LOW:
    assert property (primary_system_error_n_out == 1'h0)
        else $error("open-drain value not low");
    // No output may keep its high phase for two cycles
    AST_CLK_FULL:
    assert property (!(|(secondary_bus_clock_outputs
                         & $past(secondary_bus_clock_outputs))))
        else $error("clock high phase stretched");
    AST_RSV_ZERO:
    assert property (s_axi_rvalid |-> s_axi_rdata[15:14] == 2'h0)
        else $error("reserved clock bits read nonzero");
    AST_RD_DECERR:
    assert property (s_axi_arvalid && s_axi_arready
                     && !({s_axi_araddr[7:2], 2'h0}
                          inside {8'h68, 8'h6c, 8'h70, 8'h74})
                     |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RD_NEXT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready
                     |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    cover property ($rose(primary_system_error_n_oe));
    cover property ($fell(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h3);
endmodule

// ===== verification/tb_bcg_top.sv
// Self-checking bench for the clock gating and error cause registers.
// Assumes byte addresses 0x68..0x74 on a single aclk domain.
`timescale 1ns/100ps
module tb_bcg_top;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0]  err_event = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        primary_system_error_n_out, primary_system_error_n_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [9:0]  secondary_bus_clock_outputs;
    logic [7:0]  adr [4] = '{8'h68, 8'h6c, 8'h70, 8'h74};
    logic [31:0] rwm [4] = '{32'h3fff, 32'hff, 32'h1, 32'hff};
    int          err_total = 0;
    int          num_checks = 0;

    bcg_top u_bcg_top (.*);

    always #5 aclk = ~aclk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Address and data released separately, each at its own take
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                ad = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic ev(input logic [7:0] b, input logic e);
        @(posedge aclk);
        err_event <= b;
        @(posedge aclk);
        err_event <= 8'h00;
        #1;
        chk(primary_system_error_n_oe, e);
        chk(primary_system_error_n_out, 0);
        @(posedge aclk);
        #1;
        chk(primary_system_error_n_oe, 0);
    endtask

    // Running outputs toggle between samples, stopped ones sit low
    task automatic cchk(input logic [9:0] e);
        logic [9:0] c;
        repeat (6) @(posedge aclk);
        #1;
        c = secondary_bus_clock_outputs;
        @(posedge aclk);
        #1;
        chk(c ^ secondary_bus_clock_outputs, e);
        chk((c | secondary_bus_clock_outputs) & ~e, 0);
    endtask

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (adr[i])
        begin
            rd(adr[i]);
            chk(d, 0);
            wr(adr[i], 32'hffffffff, 4'hf);
            chk(r, bcg_pkg::RESP_OKAY);
            rd(adr[i]);
            chk(d, rwm[i]);
            wr(adr[i], 32'h0, 4'hf);
        end
        cchk(10'h3ff);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h68, 32'h1 << (2 * i), 4'h3);
            cchk(10'h3ff);
            wr(8'h68, 32'h3 << (2 * i), 4'h3);
            cchk(10'h3ff ^ (10'h1 << i));
        end
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h68, 32'h100 << i, 4'h3);
            cchk(10'h3ff ^ (10'h10 << i));
        end
        wr(8'h68, 32'hffff, 4'h3);
        cchk(10'h000);
        wr(8'h68, 32'h0, 4'h3);
        cchk(10'h3ff);
        wr(8'h70, 32'h1, 4'h1);
        wr(8'h74, 32'hff, 4'h1);
        for (int i = 0; i < 8; i++)
        begin
            ev(8'h1 << i, 1'h1);
            chk(irq, 1);
            wr(8'h68, 32'h0, 4'h4);
            rd(8'h68);
            chk(d, 32'h10000 << i);
            wr(8'h68, 32'hff0000, 4'h4);
            rd(8'h68);
            chk(d, 0);
            chk(irq, 0);
        end
        wr(8'h6c, 32'h1, 4'h1);
        ev(8'h01, 1'h0);
        wr(8'h70, 32'h0, 4'h1);
        ev(8'h02, 1'h0);
        rd(8'h68);
        chk(d, 0);
        rd(8'h40);
        chk(r, bcg_pkg::RESP_DECERR);
        wr(8'h40, 32'hffffffff, 4'hf);
        chk(r, bcg_pkg::RESP_DECERR);
        summarize;
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #200us;
        err_total++;
        summarize;
    end
endmodule

bind bcg_top bcg_top_properties #(.CLK_COUNT(CLK_COUNT))
    u_bcg_top_properties (.*);
